// ---- hdl/dicp_top.sv ----
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`include "dicp_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dicp_top (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_por,
    input wire logic [1:0] i_din,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [1:0] o_status,
    output logic o_irq
);
    localparam int NCH = `DICP_NCH;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic [7:0] aw_reg;
    logic aw_have_reg;
    logic [31:0] wd_reg;
    logic [3:0] ws_reg;
    logic wd_have_reg;
    logic wr_go;
    dicp_pkg::dicp_ctrl_s ctrl_reg [NCH];
    dicp_pkg::dicp_filt_s filt_reg [NCH];
    logic [15:0] vrst_reg;
    logic [1:0] irq_st_reg;
    logic [1:0] irq_msk_reg;
    logic [31:0] cnt_reg [NCH];
    logic [31:0] freq_reg [NCH];
    logic [1:0] stat_reg;
    logic [1:0] run_reg;
    logic [1:0] ev;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready = !wd_have_reg && !s_axi_bvalid;
    assign wr_go = aw_have_reg && wd_have_reg && !s_axi_bvalid;
    assign s_axi_bresp = 2'h0;
    assign s_axi_rresp = 2'h0;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            aw_have_reg <= 1'b0;
            wd_have_reg <= 1'b0;
            aw_reg <= 8'h00;
            wd_reg <= 32'h0000_0000;
            ws_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_reg <= s_axi_awaddr;
                aw_have_reg <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_reg <= s_axi_wdata;
                ws_reg <= s_axi_wstrb;
                wd_have_reg <= 1'b1;
            end
            if (wr_go) begin
                aw_have_reg <= 1'b0;
                wd_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wsel_cmd, wsel_irq;
    logic [31:0] cmd_w;
    assign wsel_cmd = wr_go && aw_reg == `DICP_OFF_CMD;
    assign wsel_irq = wr_go && aw_reg == `DICP_OFF_IRQ_ST;
    assign cmd_w = wsel_cmd ? wmerge(32'h0000_0000, wd_reg, ws_reg) : 32'h0000_0000;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ctrl_reg[0] <= `DICP_CTRL_RST;
            ctrl_reg[1] <= `DICP_CTRL_RST;
            filt_reg[0] <= `DICP_FILT_RST;
            filt_reg[1] <= `DICP_FILT_RST;
            vrst_reg <= `DICP_VRST_RST;
            irq_msk_reg <= 2'h0;
        end else if (wr_go) begin
            case (aw_reg)
                `DICP_OFF_CTRL0: ctrl_reg[0] <= wmerge(ctrl_reg[0], wd_reg, ws_reg) & 32'h0000_01F7;
                `DICP_OFF_CTRL1: ctrl_reg[1] <= wmerge(ctrl_reg[1], wd_reg, ws_reg) & 32'h0000_01F7;
                `DICP_OFF_FILT0: filt_reg[0] <= wmerge(filt_reg[0], wd_reg, ws_reg);
                `DICP_OFF_FILT1: filt_reg[1] <= wmerge(filt_reg[1], wd_reg, ws_reg);
                `DICP_OFF_VRST: vrst_reg <= 16'(wmerge({16'h0000, vrst_reg}, wd_reg, ws_reg));
                `DICP_OFF_IRQ_MSK: irq_msk_reg <= wd_reg[1:0];
                default: ;
            endcase
        end
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            irq_st_reg <= 2'h0;
        end else begin
            irq_st_reg <= (irq_st_reg & ~(wsel_irq ? wd_reg[1:0] : 2'h0)) | ev;
        end
    end
    assign o_irq = |(irq_st_reg & irq_msk_reg);

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                `DICP_OFF_CTRL0: s_axi_rdata <= ctrl_reg[0];
                `DICP_OFF_CTRL1: s_axi_rdata <= ctrl_reg[1];
                `DICP_OFF_FILT0: s_axi_rdata <= filt_reg[0];
                `DICP_OFF_FILT1: s_axi_rdata <= filt_reg[1];
                `DICP_OFF_STAT: s_axi_rdata <= {26'h0, run_reg, 2'h0, stat_reg};
                `DICP_OFF_CNT0: s_axi_rdata <= cnt_reg[0];
                `DICP_OFF_CNT1: s_axi_rdata <= cnt_reg[1];
                `DICP_OFF_FREQ0: s_axi_rdata <= freq_reg[0];
                `DICP_OFF_FREQ1: s_axi_rdata <= freq_reg[1];
                `DICP_OFF_IRQ_ST: s_axi_rdata <= {30'h0, irq_st_reg};
                `DICP_OFF_IRQ_MSK: s_axi_rdata <= {30'h0, irq_msk_reg};
                `DICP_OFF_VRST: s_axi_rdata <= {16'h0, vrst_reg};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Shared timebases
    // ----------------------------------------
    logic [15:0] step_div_reg;
    logic step_en;
    logic [6:0] fast_div_reg;
    logic fast_en;
    logic [9:0] ms_div_reg;
    logic [13:0] slow_div_reg;
    logic slow_en;
    logic vrst_tick;
    assign step_en = step_div_reg == 16'(`DICP_FILT_STEP_CYC - 1);
    assign fast_en = fast_div_reg == 7'(`DICP_FAST_TB_CYC - 1);
    assign slow_en = slow_div_reg == 14'(`DICP_SLOW_TB_CYC - 1);
    assign vrst_tick = slow_en && ms_div_reg == 10'(`DICP_VRST_STEP_TICKS - 1);

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            step_div_reg <= 16'h0000;
            fast_div_reg <= 7'h00;
            slow_div_reg <= 14'h0000;
            ms_div_reg <= 10'h000;
        end else begin
            step_div_reg <= step_en ? 16'h0000 : step_div_reg + 16'h0001;
            fast_div_reg <= fast_en ? 7'h00 : fast_div_reg + 7'h01;
            slow_div_reg <= slow_en ? 14'h0000 : slow_div_reg + 14'h0001;
            if (slow_en) begin
                ms_div_reg <= vrst_tick ? 10'h000 : ms_div_reg + 10'h001;
            end
        end
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    logic [15:0] fcnt_reg [NCH];
    logic [1:0] filt_lvl_reg;
    logic [1:0] prev_reg;
    logic [31:0] per_reg [NCH];
    logic [1:0] per_ok_reg;
    logic [15:0] idle_reg [NCH];
    logic [1:0] cond;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] was_retained_reg;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic raw;
        logic en;
        logic tb;
        dicp_pkg::dicp_mode_e md;
        assign md = ctrl_reg[c].mode;
        assign en = !ctrl_reg[c].mask && md != dicp_pkg::DICP_MODE_OFF; // R1 R2
        assign raw = i_din[c] ^ ctrl_reg[c].invert; // R3 R16
        assign cond[c] = ctrl_reg[c].filt_en ? filt_lvl_reg[c] : raw; // R4 R16
        assign rise[c] = cond[c] && !prev_reg[c];
        assign fall[c] = !cond[c] && prev_reg[c];
        assign tb = ctrl_reg[c].prec ? fast_en : slow_en; // R12 R18
        assign ev[c] = en && ((md == dicp_pkg::DICP_MODE_LH && rise[c] && !stat_reg[c]) ||
                              (md == dicp_pkg::DICP_MODE_HL && fall[c] && stat_reg[c]));

        // Width counter restarts whenever raw agrees with accepted level
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                fcnt_reg[c] <= 16'h0000;
                filt_lvl_reg[c] <= 1'b0;
            end else if (raw == filt_lvl_reg[c]) begin
                fcnt_reg[c] <= 16'h0000;
            end else if (step_en) begin
                if (fcnt_reg[c] + 16'h0001 >=
                    (raw ? filt_reg[c].hi_w : filt_reg[c].lo_w)) begin // R5
                    filt_lvl_reg[c] <= raw;
                    fcnt_reg[c] <= 16'h0000;
                end else begin
                    fcnt_reg[c] <= fcnt_reg[c] + 16'h0001;
                end
            end
        end

        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                prev_reg[c] <= 1'b0;
            end else begin
                prev_reg[c] <= cond[c];
            end
        end

        // Count held on warm reset; i_por marks power-up after power loss
        always_ff @(posedge i_clk) begin
            if (i_por && !ctrl_reg[c].retain) begin
                cnt_reg[c] <= 32'h0000_0000; // R10
            end else if (!i_rst_b || i_por) begin
                cnt_reg[c] <= cnt_reg[c]; // R9
            end else if (cmd_w[`DICP_CMD_CRST_LSB + c]) begin
                cnt_reg[c] <= 32'h0000_0000; // R8
            end else if (en && md == dicp_pkg::DICP_MODE_CNT && run_reg[c] && rise[c]) begin
                cnt_reg[c] <= cnt_reg[c] + 32'h0000_0001; // R6 R17
            end
        end

        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                run_reg[c] <= 1'b0;
            end else if (cmd_w[`DICP_CMD_STOP_LSB + c]) begin
                run_reg[c] <= 1'b0; // R7
            end else if (cmd_w[`DICP_CMD_START_LSB + c]) begin
                run_reg[c] <= 1'b1; // R7
            end
        end

        always_ff @(posedge i_clk) begin
            if (!i_rst_b || !en || md != dicp_pkg::DICP_MODE_FREQ) begin
                per_reg[c] <= 32'h0000_0000;
                per_ok_reg[c] <= 1'b0;
                idle_reg[c] <= 16'h0000;
                freq_reg[c] <= 32'h0000_0000;
            end else begin
                if (rise[c]) begin
                    per_reg[c] <= 32'h0000_0000;
                    per_ok_reg[c] <= 1'b1;
                    idle_reg[c] <= 16'h0000;
                    if (per_ok_reg[c] && per_reg[c] != 32'h0000_0000) begin
                        freq_reg[c] <= per_reg[c]; // R11 R18
                    end
                end else begin
                    if (tb && per_reg[c] != 32'hFFFF_FFFF) begin
                        per_reg[c] <= per_reg[c] + 32'h0000_0001;
                    end
                    if (vrst_tick) begin
                        if (idle_reg[c] + 16'h0001 >= vrst_reg) begin
                            freq_reg[c] <= 32'h0000_0000; // R13
                            per_ok_reg[c] <= 1'b0;
                        end else begin
                            idle_reg[c] <= idle_reg[c] + 16'h0001;
                        end
                    end
                end
            end
        end

        always_ff @(posedge i_clk) begin
            if (!i_rst_b || !en) begin
                stat_reg[c] <= 1'b0;
            end else begin
                case (md)
                    dicp_pkg::DICP_MODE_LH: begin
                        if (rise[c]) begin
                            stat_reg[c] <= 1'b1; // R14
                        end else if (cmd_w[`DICP_CMD_LCLR_LSB + c]) begin
                            stat_reg[c] <= 1'b0; // R14
                        end
                    end
                    dicp_pkg::DICP_MODE_HL: begin
                        if (fall[c] && was_retained_reg[c]) begin
                            stat_reg[c] <= 1'b0; // R15
                        end else if (cmd_w[`DICP_CMD_LCLR_LSB + c] || !was_retained_reg[c]) begin
                            stat_reg[c] <= 1'b1; // R15
                        end
                    end
                    default: stat_reg[c] <= cond[c];
                endcase
            end
        end

        // Falling latch starts from high on first cycle in its mode
        always_ff @(posedge i_clk) begin
            if (!i_rst_b || !en || md != dicp_pkg::DICP_MODE_HL) begin
                was_retained_reg[c] <= 1'b0;
            end else begin
                was_retained_reg[c] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_status <= 2'h0;
        end else begin
            o_status <= stat_reg;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/dicp_consts.svh ----
// Behaviour
// R1: Per channel mode: disabled, plain input, counter, frequency, rising latch, falling latch.
// R2: Mask bit disables a channel; masked channel reports zero data. The count value is held while masked, not zeroed.
// R3: Invert enable reports the complement of the pin level.
// R4: Noise filter per channel, enabled or bypassed, rejects short glitches.
// R5: Filter accepts low or high only after programmed width in 0.1 ms steps.
// R6: Counter mode counts pulses into a readable count value.
// R7: Counter start and stop commands; stopped counter ignores pulses.
// R8: Counter reset command returns the count to zero.
// R9: Retain option keeps count over power loss and resumes from it.
// R10: Without retain option, count clears to zero at power-up.
// R11: Frequency mode on plain input channels gives readable frequency value. The FREQ register holds the period count in timebase ticks, not a frequency.
// R12: Precision setting selects measurement arrangement for frequency range.
// R13: Frequency forced to zero when no pulse within value-reset time, 0.1 s units.
// R14: Rising latch holds status high until clear returns it low.
// R15: Falling latch holds status low until clear returns it high.
// R16: Order is invert, then filter, then mode logic.
// R17: Counter adds one per rising edge while running; wraps at full width.
// R18: Frequency from period between rising edges against a fixed timebase.
`ifndef DICP_CONSTS_SVH
`define DICP_CONSTS_SVH

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define DICP_NCH 2
`define DICP_CLK_MHZ 125
`define DICP_FILT_STEP_US 100
`define DICP_FILT_STEP_CYC (`DICP_FILT_STEP_US * `DICP_CLK_MHZ)
`define DICP_VRST_STEP_MS 100
`define DICP_VRST_STEP_TICKS (`DICP_VRST_STEP_MS * 10)
`define DICP_FAST_TB_CYC 125
`define DICP_SLOW_TB_CYC 12500

// ----------------------------------------
// Register map, byte offsets
// ----------------------------------------
`define DICP_OFF_CTRL0 8'h00
`define DICP_OFF_CTRL1 8'h04
`define DICP_OFF_FILT0 8'h08
`define DICP_OFF_FILT1 8'h0C
`define DICP_OFF_CMD 8'h10
`define DICP_OFF_STAT 8'h14
`define DICP_OFF_CNT0 8'h18
`define DICP_OFF_CNT1 8'h1C
`define DICP_OFF_FREQ0 8'h20
`define DICP_OFF_FREQ1 8'h24
`define DICP_OFF_IRQ_ST 8'h28
`define DICP_OFF_IRQ_MSK 8'h2C
`define DICP_OFF_VRST 8'h30

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DICP_CTRL_MODE_LSB 0
`define DICP_CTRL_MASK_BIT 4
`define DICP_CTRL_INV_BIT 5
`define DICP_CTRL_FILT_BIT 6
`define DICP_CTRL_RET_BIT 7
`define DICP_CTRL_PREC_BIT 8
`define DICP_CMD_START_LSB 0
`define DICP_CMD_STOP_LSB 2
`define DICP_CMD_CRST_LSB 4
`define DICP_CMD_LCLR_LSB 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DICP_CTRL_RST 32'h0000_0001
`define DICP_FILT_RST 32'h0001_0001
`define DICP_VRST_RST 16'h000A

`endif

// ---- hdl/dicp_pkg.sv ----
package dicp_pkg;
    typedef enum logic [2:0] {
        DICP_MODE_OFF = 3'b000,
        DICP_MODE_DI = 3'b001,
        DICP_MODE_CNT = 3'b010,
        DICP_MODE_FREQ = 3'b011,
        DICP_MODE_LH = 3'b100,
        DICP_MODE_HL = 3'b101
    } dicp_mode_e;

    typedef struct packed {
        logic [22:0] rsv;
        logic prec;
        logic retain;
        logic filt_en;
        logic invert;
        logic mask;
        logic [0:0] rsv2;
        dicp_mode_e mode;
    } dicp_ctrl_s;

    typedef struct packed {
        logic [15:0] hi_w;
        logic [15:0] lo_w;
    } dicp_filt_s;
endpackage

// ---- test/dicp_top_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module dicp_top_chk (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] o_status,
    input wire logic o_irq
);
    // ------
    // Bus and status checks
    // ------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    AST_RST_QUIET: assert property (disable iff (1'h0) !i_rst_b |=> !s_axi_bvalid && !s_axi_rvalid && o_status == 2'h0 && !o_irq)
        else $error("not quiet after reset");
    AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    AST_OKAY: assert property ((s_axi_bvalid || s_axi_rvalid) |-> s_axi_bresp == 2'h0 && s_axi_rresp == 2'h0)
        else $error("response code not okay");
    AST_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    AST_ZERO_READ: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr >= 8'h34 || s_axi_araddr == 8'h10) |=> s_axi_rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_IRQ_FALL: assert property ($fell(o_irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt dropped without write");
endmodule
bind dicp_top dicp_top_chk chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .o_status(o_status), .o_irq(o_irq));
`default_nettype wire

// ---- test/dicp_field_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module dicp_field_src (
    input wire logic i_clk,
    input wire logic [1:0] i_level,
    input wire logic i_sq_en,
    input wire logic [15:0] i_half,
    output logic [1:0] o_din
);
    // ------
    // Field source: static levels or square wave on channel 0
    // ------
    logic [15:0] cnt_reg;
    logic sq_reg;
    always_ff @(posedge i_clk) begin
        if (!i_sq_en) begin
            cnt_reg <= 16'h0;
            sq_reg <= 1'h0;
        end else if (cnt_reg >= i_half - 16'h1) begin
            cnt_reg <= 16'h0;
            sq_reg <= ~sq_reg;
        end else begin
            cnt_reg <= cnt_reg + 16'h1;
        end
    end
    assign o_din = {i_level[1], i_sq_en ? sq_reg : i_level[0]};
endmodule
`default_nettype wire

// ---- test/dicp_top_tb_top.sv ----
`include "dicp_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dicp_top_tb_top;
    logic i_clk, i_rst_b, i_por, sq_en, o_irq;
    logic [1:0] lvl, din, bresp, rresp, o_status;
    logic [15:0] half;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    int err_total, total_checks, cyc;
    typedef struct packed {
        logic wen; logic [7:0] wa; logic [31:0] wd; logic [1:0] din; logic [7:0] ra; logic [31:0] want;
    } dicp_row_s;
    dicp_row_s rows [16] = '{
        '{1'h0, 8'h0, 32'h0, 2'h0, `DICP_OFF_CTRL0, `DICP_CTRL_RST},
        '{1'h0, 8'h0, 32'h0, 2'h0, `DICP_OFF_CTRL1, `DICP_CTRL_RST},
        '{1'h0, 8'h0, 32'h0, 2'h0, `DICP_OFF_FILT1, `DICP_FILT_RST},
        '{1'h0, 8'h0, 32'h0, 2'h0, `DICP_OFF_VRST, 32'hA},
        '{1'h0, 8'h0, 32'h0, 2'h0, `DICP_OFF_IRQ_MSK, 32'h0},
        '{1'h0, 8'h0, 32'h0, 2'h0, `DICP_OFF_CMD, 32'h0},
        '{1'h1, 8'h40, 32'hFFFFFFFF, 2'h0, 8'h40, 32'h0},
        '{1'h1, `DICP_OFF_CTRL1, 32'h1E2, 2'h0, `DICP_OFF_CTRL1, 32'h1E2},
        '{1'h1, `DICP_OFF_IRQ_MSK, 32'hFFFFFFFF, 2'h0, `DICP_OFF_IRQ_MSK, 32'h3},
        '{1'h1, `DICP_OFF_CTRL1, 32'h1, 2'h0, `DICP_OFF_STAT, 32'h0},
        '{1'h1, `DICP_OFF_CTRL0, 32'h1, 2'h1, `DICP_OFF_STAT, 32'h1},
        '{1'h1, `DICP_OFF_CTRL0, 32'h21, 2'h1, `DICP_OFF_STAT, 32'h0},
        '{1'h1, `DICP_OFF_CTRL0, 32'h21, 2'h0, `DICP_OFF_STAT, 32'h1},
        '{1'h1, `DICP_OFF_CTRL0, 32'h11, 2'h1, `DICP_OFF_STAT, 32'h0},
        '{1'h1, `DICP_OFF_CTRL0, 32'h0, 2'h1, `DICP_OFF_STAT, 32'h0},
        '{1'h1, `DICP_OFF_CTRL0, 32'h1, 2'h2, `DICP_OFF_STAT, 32'h2}};

    dicp_field_src src (.i_clk(i_clk), .i_level(lvl), .i_sq_en(sq_en), .i_half(half), .o_din(din));
    dicp_top uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_por(i_por), .i_din(din),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
        .o_status(o_status), .o_irq(o_irq));

    // ------
    // Clock, timeout and shared tasks
    // ------
    initial begin
        i_clk = 1'h0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi);
        total_checks++;
        if (!((rd >= lo && rd <= hi) === 1'h1)) begin
            err_total++;
            $display("wrong value %s expected %0d to %0d seen %h", nm, lo, hi, rd);
        end
    endtask
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge i_clk);
            n++;
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 100);
        if (n >= 100) err_total++;
    endtask
    task automatic rdr(input logic [7:0] a);
        int n = 0;
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge i_clk);
            n++;
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 100);
        rd = rdata;
        if (n >= 100) err_total++;
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            lvl[0] <= 1'h1;
            cyc_wait(3);
            lvl[0] <= 1'h0;
            cyc_wait(3);
        end
    endtask
    task automatic por();
        i_por <= 1'h1;
        cyc_wait(1);
        i_por <= 1'h0;
        cyc_wait(2);
    endtask

    // ------
    // Main sequence
    // ------
    initial begin
        {err_total, total_checks, cyc} = 0;
        {i_rst_b, sq_en, awvalid, wvalid, arvalid} = 0;
        {lvl, awaddr, araddr, wdata} = 0;
        i_por = 1'h1;
        half = 16'd500;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'h1;
        i_por <= 1'h0;
        foreach (rows[i]) begin
            lvl <= rows[i].din;
            if (rows[i].wen) wr(rows[i].wa, rows[i].wd);
            cyc_wait(4);
            rdr(rows[i].ra);
            check($sformatf("row%0d", i), rows[i].want, rd);
        end
        lvl <= 2'h0;
        wr(`DICP_OFF_CTRL0, 32'h2);
        wr(`DICP_OFF_CMD, 32'h1);
        pulse(5);
        rdr(`DICP_OFF_CNT0);
        check("count", 32'h5, rd);
        rdr(`DICP_OFF_STAT);
        check("running", 32'h1, {30'h0, rd[5:4]});
        wr(`DICP_OFF_CMD, 32'h4);
        pulse(3);
        wr(`DICP_OFF_CMD, 32'h5);
        pulse(2);
        rdr(`DICP_OFF_CNT0);
        check("count stopped", 32'h5, rd);
        wr(`DICP_OFF_CTRL0, 32'h82);
        por();
        rdr(`DICP_OFF_CNT0);
        check("count kept", 32'h5, rd);
        wr(`DICP_OFF_CMD, 32'h1);
        pulse(1);
        rdr(`DICP_OFF_CNT0);
        check("count resumed", 32'h6, rd);
        wr(`DICP_OFF_CTRL0, 32'h2);
        por();
        rdr(`DICP_OFF_CNT0);
        check("count powered", 32'h0, rd);
        wr(`DICP_OFF_CMD, 32'h1);
        pulse(3);
        wr(`DICP_OFF_CMD, 32'h10);
        rdr(`DICP_OFF_CNT0);
        check("count cleared", 32'h0, rd);
        wr(`DICP_OFF_IRQ_ST, 32'h3);
        wr(`DICP_OFF_CTRL0, 32'h4);
        cyc_wait(4);
        check("irq idle", 32'h0, {31'h0, o_irq});
        pulse(1);
        rdr(`DICP_OFF_STAT);
        check("rise latch", 32'h1, {31'h0, rd[0]});
        check("irq set", 32'h1, {31'h0, o_irq});
        wr(`DICP_OFF_IRQ_MSK, 32'h2);
        cyc_wait(1);
        check("irq masked", 32'h0, {31'h0, o_irq});
        wr(`DICP_OFF_IRQ_MSK, 32'h3);
        cyc_wait(1);
        check("irq unmasked", 32'h1, {31'h0, o_irq});
        wr(`DICP_OFF_IRQ_ST, 32'h1);
        cyc_wait(1);
        check("irq cleared", 32'h0, {31'h0, o_irq});
        wr(`DICP_OFF_CMD, 32'h40);
        rdr(`DICP_OFF_STAT);
        check("rise clear", 32'h0, {31'h0, rd[0]});
        lvl[0] <= 1'h1;
        wr(`DICP_OFF_CTRL0, 32'h5);
        cyc_wait(4);
        rdr(`DICP_OFF_STAT);
        check("fall idle", 32'h1, {31'h0, rd[0]});
        pulse(1);
        lvl[0] <= 1'h1;
        cyc_wait(4);
        rdr(`DICP_OFF_STAT);
        check("fall latch", 32'h0, {31'h0, rd[0]});
        wr(`DICP_OFF_CMD, 32'h40);
        rdr(`DICP_OFF_STAT);
        check("fall clear", 32'h1, {31'h0, rd[0]});
        check("status pin", 32'h1, {30'h0, o_status});
        i_rst_b <= 1'h0;
        cyc_wait(2);
        i_rst_b <= 1'h1;
        cyc_wait(1);
        check("irq reset", 32'h0, {31'h0, o_irq});
        rdr(`DICP_OFF_CTRL0);
        check("ctrl reset", `DICP_CTRL_RST, rd);
        wr(`DICP_OFF_CTRL0, 32'h3);
        sq_en <= 1'h1;
        cyc_wait(3000);
        rdr(`DICP_OFF_FREQ0);
        check_rng("freq coarse", 32'd0, 32'd1);
        wr(`DICP_OFF_CTRL0, 32'h103);
        cyc_wait(3500);
        rdr(`DICP_OFF_FREQ0);
        check_rng("freq fine", 32'd7, 32'd9);
        wr(`DICP_OFF_CTRL0, 32'h1);
        rdr(`DICP_OFF_FREQ0);
        check("freq off", 32'h0, rd);
        sq_en <= 1'h0;
        lvl[0] <= 1'h0;
        wr(`DICP_OFF_CTRL0, 32'h41);
        wr(`DICP_OFF_FILT0, 32'h20001);
        cyc_wait(26000);
        lvl[0] <= 1'h1;
        cyc_wait(100);
        lvl[0] <= 1'h0;
        cyc_wait(10);
        lvl[0] <= 1'h1;
        cyc_wait(6000);
        rdr(`DICP_OFF_STAT);
        check("filter hold", 32'h0, {31'h0, rd[0]});
        cyc_wait(20000);
        rdr(`DICP_OFF_STAT);
        check("filter accept", 32'h1, {31'h0, rd[0]});
        finish_test();
    end
endmodule
`default_nettype wire
